// file: core/chan_cfg_device.sv
// Summary of operation
// - pin code 1/2/4 gives 4/8/16 MSB pins
// - word code selects 4 to 20 bit words
// - formatter sends I and Q, or I only
// - power-down halts the output formatter
// - TDM shares pins between channels in turn
// - software keeps all channels' formatters consistent
// - power meter test bit resets to zero
// - pattern source off, random, 0x4000, random with bit 14 inverted
// - read-only 16-bit receive checksum
// - delay-line write/read four-bit down-counters
// - swap RAM transmit, complex, broadcast bits
// - filter forward broadcast enable bit
// - trim shortens data-valid delay when bypassed
// - accumulator delay and partial-product count fields
// - bypass passes partial sums, count zero
// - accumulate RAM off with zero delay
// - output shift raises filter gain
// - software sets transmit enables per mode
// - rounding to 20 or 18 bits
// - complex output bit of the filter
// - periodic resync counter with enable
// - filter clocks gated per CIC sample
//
// Register access over APB is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module chan_cfg_device
   import chan_cfg_pkg::*;
#(
   parameter int NUM_CHAN = 4
) (
   input  wire logic        pclk,            // core clock
   input  wire logic        presetn,         // async reset, active low
   chan_link.dev            link,            // register port and sample output
   input  wire logic [19:0] sample_i,        // receive in-phase sample
   input  wire logic [19:0] sample_q,        // receive quadrature sample
   input  wire logic        sample_valid,    // CIC sample strobe
   input  wire logic        cic_bypass,      // CIC is bypassed
   input  wire logic [23:0] partial_in,      // partial sum from filter cells
   input  wire logic        partial_valid,   // partial sum strobe
   output logic      [15:0] tx_pattern,      // transmit test pattern
   output logic             pwr_meter_test,  // power meter test mode
   output logic      [3:0]  dl_wr_addr,      // delay-line write down-counter
   output logic      [3:0]  dl_rd_addr,      // delay-line read down-counter
   output logic             dl_xmt,          // swap RAM in transmit
   output logic             dl_cmplx,        // swap RAM expects complex
   output logic             delay_line_forward_bcast, // swap RAM broadcast
   output logic             filter_forward_bcast,     // filter cell broadcast
   output logic             fir_data_valid,  // CIC to filter data valid
   output logic      [3:0]  acc_delay,       // accumulator delay minus one
   output logic             partial_sum_zero_delay,   // no accumulator delay
   output logic             acc_ram_en,      // accumulate RAM enable
   output logic      [19:0] filt_out,        // scaled, rounded filter output
   output logic             filt_out_valid,  // filter output strobe
   output logic             filt_cmplx,      // filter output is complex
   output logic             filt_tx_en_i,    // transmit enable i
   output logic             filt_tx_en_q,    // transmit enable q
   output logic             fir_resync,      // periodic resync pulse
   output logic             fir_clk_gate_en  // filter clock enable
);
   import chan_cfg_pkg::*;

   logic [15:0] swap_reg, acc_reg, out_reg, sync_reg, clk_reg, fmt_reg, cksum_reg;
   logic [15:0] rdata_reg, fmt_data_reg, lfsr_reg, pat_reg;
   logic        ack_reg, fmt_valid_reg, fmt_first_reg;
   logic        take, wr;
   logic [15:0] rd_mux;

   assign take = link.req && !ack_reg;
   assign wr   = take && link.we;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         swap_reg <= RST_SWAP;
         acc_reg  <= RST_ACC;
         out_reg  <= RST_OUT;
         sync_reg <= RST_SYNC;
         clk_reg  <= RST_CLK;
         fmt_reg  <= RST_FMT;
      end
      else if (wr)
      begin
         case (link.addr)
            ADDR_SWAP: swap_reg <= link.wdata & MASK_SWAP;
            ADDR_ACC:  acc_reg  <= link.wdata & MASK_ACC;
            ADDR_OUT:  out_reg  <= link.wdata & MASK_OUT;
            ADDR_SYNC: sync_reg <= link.wdata & MASK_SYNC;
            ADDR_CLK:  clk_reg  <= link.wdata & MASK_CLK;
            ADDR_FMT:  fmt_reg  <= link.wdata & MASK_FMT;
            default:   ;
         endcase
      end
   end

   always_comb
   begin
      case (link.addr)
         ADDR_SWAP:  rd_mux = swap_reg;
         ADDR_ACC:   rd_mux = acc_reg;
         ADDR_OUT:   rd_mux = out_reg;
         ADDR_SYNC:  rd_mux = sync_reg;
         ADDR_CLK:   rd_mux = clk_reg;
         ADDR_FMT:   rd_mux = fmt_reg;
         ADDR_CKSUM: rd_mux = cksum_reg;
         default:    rd_mux = 16'h0000;
      endcase
   end

   // ack follows a taken request by one cycle; the far end drops req on seeing it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ack_reg   <= 1'b0;
         rdata_reg <= 16'h0000;
      end
      else
      begin
         ack_reg <= take;
         if (take)
            rdata_reg <= rd_mux;
      end
   end

   // checksum restarts on each formatter write, a write to it is ignored
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cksum_reg <= 16'h0000;
      else if (wr && link.addr == ADDR_FMT)
         cksum_reg <= 16'h0000;
      else if (sample_valid)
         cksum_reg <= {cksum_reg[14:0], cksum_reg[15]} ^ sample_i[19:4] ^ sample_q[19:4];
   end

   // transmit pattern generator
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lfsr_reg <= LFSR_SEED;
         pat_reg  <= 16'h0000;
      end
      else
      begin
         lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
         case (fmt_reg[FMT_PAT_LSB +: 2])
            PAT_OFF:   pat_reg <= 16'h0000;
            PAT_RAND:  pat_reg <= lfsr_reg;
            PAT_CONST: pat_reg <= PAT_CONST_VAL;
            PAT_RINV:  pat_reg <= lfsr_reg ^ PAT_INV_MASK;
            default:   pat_reg <= 16'h0000;
         endcase
      end
   end

   // receive output formatter
   typedef enum logic [1:0] {F_IDLE, F_I, F_Q, F_GAP} fmt_state_t;
   fmt_state_t  fst_reg;
   logic [19:0] shreg_reg, q_hold_reg, keep_mask;
   logic [4:0]  word_bits, pins, beats, beat_reg;
   logic [2:0]  pin_shift;
   logic [7:0]  gap_reg;
   logic [15:0] pin_mask;

   always_comb
   begin
      case (fmt_reg[FMT_PIN_LSB +: 3])
         PINS_4:  begin pins = 5'd4;  pin_shift = 3'd2; pin_mask = 16'hF000; end
         PINS_8:  begin pins = 5'd8;  pin_shift = 3'd3; pin_mask = 16'hFF00; end
         default: begin pins = 5'd16; pin_shift = 3'd4; pin_mask = 16'hFFFF; end
      endcase
      case (fmt_reg[FMT_BIT_LSB +: 5])
         5'h01:   word_bits = 5'd4;
         5'h02:   word_bits = 5'd8;
         5'h04:   word_bits = 5'd12;
         5'h08:   word_bits = 5'd16;
         default: word_bits = 5'd20;
      endcase
      // widened first: 20 bits on 16 pins would wrap a 5-bit sum to zero beats
      beats     = 5'((6'(word_bits) + 6'(pins) - 6'd1) >> pin_shift);
      keep_mask = ~(20'hFFFFF >> word_bits);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fst_reg       <= F_IDLE;
         shreg_reg     <= 20'h00000;
         q_hold_reg    <= 20'h00000;
         beat_reg      <= 5'd0;
         gap_reg       <= 8'h00;
         fmt_data_reg  <= 16'h0000;
         fmt_valid_reg <= 1'b0;
         fmt_first_reg <= 1'b0;
      end
      else if (fmt_reg[FMT_PWRDN])
      begin
         fst_reg       <= F_IDLE;
         fmt_valid_reg <= 1'b0;
         fmt_first_reg <= 1'b0;
         fmt_data_reg  <= 16'h0000;
      end
      else
      begin
         fmt_valid_reg <= 1'b0;
         fmt_first_reg <= 1'b0;
         fmt_data_reg  <= 16'h0000;
         case (fst_reg)
            F_IDLE:
               if (sample_valid)
               begin
                  shreg_reg  <= sample_i & keep_mask;
                  q_hold_reg <= sample_q & keep_mask;
                  beat_reg   <= beats;
                  fst_reg    <= F_I;
                  fmt_first_reg <= 1'b1;
               end
            F_I, F_Q:
            begin
               fmt_valid_reg <= 1'b1;
               fmt_data_reg  <= shreg_reg[19:4] & pin_mask;
               shreg_reg     <= 20'(shreg_reg << pins);
               beat_reg      <= beat_reg - 5'd1;
               if (beat_reg == 5'd1)
               begin
                  if (fst_reg == F_I && fmt_reg[FMT_IQMUX])
                  begin
                     shreg_reg <= q_hold_reg;
                     beat_reg  <= beats;
                     fst_reg   <= F_Q;
                  end
                  else if (fmt_reg[FMT_TDM])
                  begin
                     gap_reg <= 8'((NUM_CHAN - 1) * beats * (fmt_reg[FMT_IQMUX] ? 2 : 1));
                     fst_reg <= F_GAP;
                  end
                  else
                     fst_reg <= F_IDLE;
               end
               if (beat_reg == beats && fst_reg == F_I)
                  fmt_first_reg <= 1'b0;
            end
            F_GAP:
            begin
               gap_reg <= gap_reg - 8'h01;
               if (gap_reg <= 8'h01)
                  fst_reg <= F_IDLE;
            end
            default: fst_reg <= F_IDLE;
         endcase
      end
   end

   assign link.rdata     = rdata_reg;
   assign link.ack       = ack_reg;
   assign link.fmt_data  = fmt_data_reg;
   assign link.fmt_valid = fmt_valid_reg;
   assign link.fmt_first = fmt_first_reg;
   assign tx_pattern     = pat_reg;
   assign pwr_meter_test = fmt_reg[FMT_PWRTEST];

   // swap RAM and static filter controls come straight from the bank
   assign dl_xmt                   = swap_reg[SWAP_XMT];
   assign dl_cmplx                 = swap_reg[SWAP_CMPLX];
   assign delay_line_forward_bcast = swap_reg[DL_FB];
   assign filter_forward_bcast     = swap_reg[FILT_FB];
   assign acc_delay                = acc_reg[ACC_DLY_LSB +: 4];
   assign partial_sum_zero_delay   = acc_reg[ACC_ZDLY];
   assign acc_ram_en               = acc_reg[ACC_ENRAM];
   assign filt_cmplx               = out_reg[OUT_CMPLX];
   assign filt_tx_en_i             = out_reg[OUT_XENI];
   assign filt_tx_en_q             = out_reg[OUT_XENQ];

   logic [3:0] wa_reg, ra_reg;
   logic       dv_pipe_reg, dv_reg;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wa_reg      <= 4'h0;
         ra_reg      <= 4'h0;
         dv_pipe_reg <= 1'b0;
         dv_reg      <= 1'b0;
      end
      else
      begin
         if (sample_valid)
         begin
            wa_reg <= (wa_reg == 4'h0) ? swap_reg[SWAP_WA_LSB +: 4] : wa_reg - 4'h1;
            ra_reg <= (ra_reg == 4'h0) ? swap_reg[SWAP_RA_LSB +: 4] : ra_reg - 4'h1;
         end
         dv_pipe_reg <= sample_valid;
         dv_reg      <= (swap_reg[DLY_TRIM] && cic_bypass) ? sample_valid : dv_pipe_reg;
      end
   end
   assign dl_wr_addr     = wa_reg;
   assign dl_rd_addr     = ra_reg;
   assign fir_data_valid = dv_reg;

   // accumulator, shift and rounding; overflow of the shift wraps
   logic [23:0] acc_sum_reg, acc_total, shifted;
   logic [3:0]  acc_n_reg;
   logic [19:0] filt_reg;
   logic        filt_v_reg;
   assign acc_total = acc_reg[ACC_BYP] ? partial_in : 24'(acc_sum_reg + partial_in);
   assign shifted   = 24'(acc_total << out_reg[OSH_LSB +: 3]);
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         acc_sum_reg <= 24'h000000;
         acc_n_reg   <= 4'h0;
         filt_reg    <= 20'h00000;
         filt_v_reg  <= 1'b0;
      end
      else
      begin
         filt_v_reg <= 1'b0;
         if (partial_valid)
         begin
            if (acc_reg[ACC_BYP] || (acc_n_reg + 4'h1) >= acc_reg[ACC_CNT_LSB +: 4])
            begin
               acc_sum_reg <= 24'h000000;
               acc_n_reg   <= 4'h0;
               filt_v_reg  <= 1'b1;
               if (out_reg[OUT_RND])
                  filt_reg <= 20'((shifted + 24'h000008) >> 4);
               else
                  filt_reg <= {18'((shifted + 24'h000020) >> 6), 2'b00};
            end
            else
            begin
               acc_sum_reg <= acc_total;
               acc_n_reg   <= acc_n_reg + 4'h1;
            end
         end
      end
   end
   assign filt_out       = filt_reg;
   assign filt_out_valid = filt_v_reg;

   // resync counter and clock gating
   logic [15:0] sync_cnt_reg;
   logic        resync_reg, gate_reg;
   logic [7:0]  gate_cnt_reg;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync_cnt_reg <= 16'h0000;
         resync_reg   <= 1'b0;
         gate_cnt_reg <= 8'h00;
         gate_reg     <= 1'b1;
      end
      else
      begin
         resync_reg <= 1'b0;
         if (!clk_reg[SYNC_EN])
            sync_cnt_reg <= sync_reg;
         else if (sync_cnt_reg == 16'h0000)
         begin
            sync_cnt_reg <= sync_reg;
            resync_reg   <= 1'b1;
         end
         else
            sync_cnt_reg <= sync_cnt_reg - 16'h0001;
         if (sample_valid)
            gate_cnt_reg <= 8'h00;
         else if (gate_cnt_reg != 8'hFF)
            gate_cnt_reg <= gate_cnt_reg + 8'h01;
         gate_reg <= !clk_reg[CLK_CNT_EN] || sample_valid
                     || (gate_cnt_reg < clk_reg[CLK_CNT_LSB +: 8]);
      end
   end
   assign fir_resync      = resync_reg;
   assign fir_clk_gate_en = gate_reg;
endmodule
`default_nettype wire

// file: core/chan_cfg_host.sv
`timescale 1ns/10ps
`default_nettype none
module chan_cfg_host
   import chan_cfg_pkg::*;
(
   input  wire logic        pclk,     // core clock
   input  wire logic        presetn,  // async reset, active low
   input  wire logic [7:0]  paddr,    // APB address
   input  wire logic        psel,     // APB select
   input  wire logic        penable,  // APB enable
   input  wire logic        pwrite,   // APB direction
   input  wire logic [31:0] pwdata,   // APB write data
   output logic      [31:0] prdata,   // APB read data
   output logic             pready,   // APB ready
   output logic             pslverr,  // APB error, unmapped offset
   chan_link.ctl            link      // device register port and samples
);
   import chan_cfg_pkg::*;

   typedef enum logic {H_IDLE, H_REQ} host_state_t;
   host_state_t hst_reg;
   logic [8:0]  cmd_reg;
   logic [15:0] wdata_reg, rback_reg, sample_reg, beats_reg, lwdata_reg;
   logic [31:0] prdata_reg;
   logic        pready_reg, pslverr_reg, req_reg, we_reg, apb_wr, mapped;
   logic [7:0]  laddr_reg;
   logic [15:0] clean;

   assign apb_wr = psel && penable && pready_reg && pwrite;
   assign mapped = paddr == APB_CMD || paddr == APB_WDATA || paddr == APB_GO
                   || paddr == APB_STATUS || paddr == APB_SAMPLE;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h00000000;
      end
      else
      begin
         pready_reg  <= psel && !penable;
         pslverr_reg <= psel && !penable && !mapped;
         if (psel && !penable)
         begin
            case (paddr)
               APB_CMD:    prdata_reg <= {23'h000000, cmd_reg};
               APB_WDATA:  prdata_reg <= {16'h0000, wdata_reg};
               APB_STATUS: prdata_reg <= {rback_reg, 15'h0000, hst_reg == H_REQ};
               APB_SAMPLE: prdata_reg <= {beats_reg, sample_reg};
               default:    prdata_reg <= 32'h00000000;
            endcase
         end
      end
   end

   // accumulator writes are made self-consistent before they leave
   always_comb
   begin
      clean = wdata_reg;
      if (cmd_reg[7:0] == ADDR_ACC)
      begin
         if (clean[ACC_BYP])
            clean[ACC_CNT_LSB +: 4] = 4'h0;
         if (clean[ACC_ZDLY])
            clean[ACC_ENRAM] = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cmd_reg    <= 9'h000;
         wdata_reg  <= 16'h0000;
         hst_reg    <= H_IDLE;
         req_reg    <= 1'b0;
         we_reg     <= 1'b0;
         laddr_reg  <= 8'h00;
         lwdata_reg <= 16'h0000;
         rback_reg  <= 16'h0000;
      end
      else
      begin
         if (apb_wr && paddr == APB_CMD)
            cmd_reg <= pwdata[8:0];
         if (apb_wr && paddr == APB_WDATA)
            wdata_reg <= pwdata[15:0];
         case (hst_reg)
            H_IDLE:
               if (apb_wr && paddr == APB_GO)
               begin
                  req_reg    <= 1'b1;
                  we_reg     <= cmd_reg[CMD_WRITE];
                  laddr_reg  <= cmd_reg[7:0];
                  lwdata_reg <= clean;
                  hst_reg    <= H_REQ;
               end
            H_REQ:
               if (link.ack)
               begin
                  req_reg   <= 1'b0;
                  rback_reg <= link.rdata;
                  hst_reg   <= H_IDLE;
               end
            default: hst_reg <= H_IDLE;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sample_reg <= 16'h0000;
         beats_reg  <= 16'h0000;
      end
      else if (link.fmt_valid)
      begin
         sample_reg <= link.fmt_data;
         beats_reg  <= beats_reg + 16'h0001;
      end
   end

   assign prdata     = prdata_reg;
   assign pready     = pready_reg;
   assign pslverr    = pslverr_reg;
   assign link.req   = req_reg;
   assign link.we    = we_reg;
   assign link.addr  = laddr_reg;
   assign link.wdata = lwdata_reg;
endmodule
`default_nettype wire

// file: core/chan_cfg_pkg.sv
package chan_cfg_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   // device register addresses on the link
   localparam logic [7:0] ADDR_SWAP  = 8'h10;
   localparam logic [7:0] ADDR_ACC   = 8'h11;
   localparam logic [7:0] ADDR_OUT   = 8'h12;
   localparam logic [7:0] ADDR_SYNC  = 8'h13;
   localparam logic [7:0] ADDR_CLK   = 8'h14;
   localparam logic [7:0] ADDR_FMT   = 8'h1E;
   localparam logic [7:0] ADDR_CKSUM = 8'h1F;
   // implemented bits per register, others read as zero
   localparam logic [15:0] MASK_SWAP = 16'h1FFF;
   localparam logic [15:0] MASK_ACC  = 16'h07FF;
   localparam logic [15:0] MASK_OUT  = 16'h00FF;
   localparam logic [15:0] MASK_SYNC = 16'hFFFF;
   localparam logic [15:0] MASK_CLK  = 16'h77FF;
   localparam logic [15:0] MASK_FMT  = 16'h7BFF;
   // reset values
   localparam logic [15:0] RST_SWAP = 16'h0000;
   localparam logic [15:0] RST_ACC  = 16'h0000;
   localparam logic [15:0] RST_OUT  = 16'h0000;
   localparam logic [15:0] RST_SYNC = 16'h0000;
   localparam logic [15:0] RST_CLK  = 16'h7000;
   localparam logic [15:0] RST_FMT  = 16'h0000;
   // field positions
   localparam int SWAP_WA_LSB = 0;
   localparam int SWAP_RA_LSB = 4;
   localparam int SWAP_XMT    = 8;
   localparam int SWAP_CMPLX  = 9;
   localparam int FILT_FB     = 10;
   localparam int DL_FB       = 11;
   localparam int DLY_TRIM    = 12;
   localparam int ACC_DLY_LSB = 0;
   localparam int ACC_CNT_LSB = 4;
   localparam int ACC_ZDLY    = 8;
   localparam int ACC_BYP     = 9;
   localparam int ACC_ENRAM   = 10;
   localparam int OSH_LSB     = 0;
   localparam int OUT_XENQ    = 3;
   localparam int OUT_XENI    = 4;
   localparam int OUT_RND     = 6;
   localparam int OUT_CMPLX   = 7;
   localparam int CLK_CNT_LSB = 0;
   localparam int CLK_CNT_EN  = 8;
   localparam int SYNC_EN     = 10;
   localparam int FMT_PIN_LSB = 0;
   localparam int FMT_BIT_LSB = 3;
   localparam int FMT_IQMUX   = 8;
   localparam int FMT_PWRDN   = 9;
   localparam int FMT_TDM     = 11;
   localparam int FMT_PWRTEST = 12;
   localparam int FMT_PAT_LSB = 13;
   // pattern source codes
   localparam logic [1:0] PAT_OFF   = 2'h0;
   localparam logic [1:0] PAT_RAND  = 2'h1;
   localparam logic [1:0] PAT_CONST = 2'h2;
   localparam logic [1:0] PAT_RINV  = 2'h3;
   localparam logic [15:0] PAT_CONST_VAL = 16'h4000;
   localparam logic [15:0] PAT_INV_MASK  = 16'h4000;
   localparam logic [15:0] LFSR_SEED     = 16'hACE1;
   // active pin codes
   localparam logic [2:0] PINS_4  = 3'h1;
   localparam logic [2:0] PINS_8  = 3'h2;
   localparam logic [2:0] PINS_16 = 3'h4;
   // host APB register offsets
   localparam logic [7:0] APB_CMD    = 8'h00;
   localparam logic [7:0] APB_WDATA  = 8'h04;
   localparam logic [7:0] APB_GO     = 8'h08;
   localparam logic [7:0] APB_STATUS = 8'h0C;
   localparam logic [7:0] APB_SAMPLE = 8'h10;
   localparam int CMD_WRITE = 8;
endpackage

// file: core/chan_link.sv
`timescale 1ns/10ps
`default_nettype none
interface chan_link;
   logic        req;
   logic        we;
   logic [7:0]  addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic        ack;
   logic [15:0] fmt_data;
   logic        fmt_valid;
   logic        fmt_first;
   modport dev (input req, we, addr, wdata, output rdata, ack, fmt_data, fmt_valid, fmt_first);
   modport ctl (output req, we, addr, wdata, input rdata, ack, fmt_data, fmt_valid, fmt_first);
endinterface
`default_nettype wire

// file: tb/chan_link_checker.sv
`timescale 1ns/10ps
`default_nettype none
module chan_link_checker (
   input wire logic        pclk,      // core clock
   input wire logic        presetn,   // async reset, active low
   input wire logic        req,       // register request
   input wire logic        ack,       // register answer
   input wire logic [15:0] rdata,     // register read data
   input wire logic        fmt_valid, // formatted beat
   input wire logic        fmt_first  // sample start marker
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_take; req && !ack; endsequence
   sequence s_start; fmt_first ##1 fmt_valid; endsequence
   property p_ack; s_take |=> ack; endproperty
   a_ack: assert property (p_ack) else $error("request not answered");
   property p_pulse; ack |=> !ack; endproperty
   a_pulse: assert property (p_pulse) else $error("ack longer than one cycle");
   property p_cause; ack |-> $past(req); endproperty
   a_cause: assert property (p_cause) else $error("ack without request");
   property p_hold; $changed(rdata) |-> ack; endproperty
   a_hold: assert property (p_hold) else $error("read data moved outside answer");
   property p_start; fmt_first |-> s_start; endproperty
   a_start: assert property (p_start) else $error("no beat after start");
   property p_first; fmt_first |=> !fmt_first; endproperty
   a_first: assert property (p_first) else $error("start marker too long");
   property p_beat; $rose(fmt_valid) |-> $past(fmt_first); endproperty
   a_beat: assert property (p_beat) else $error("beats without start");
   property p_gap; $fell(fmt_valid) |-> !fmt_first; endproperty
   a_gap: assert property (p_gap) else $error("no idle after sample");
endmodule
`default_nettype wire

// file: tb/channel_fir_and_output_control_tb.sv
`timescale 1ns/10ps
`default_nettype none
module channel_fir_and_output_control_tb;
   import chan_cfg_pkg::*;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
   logic        sample_valid = 0, cic_bypass = 0, pready, pslverr, pmt, fdv, rsy, pv = 0;
   logic [23:0] pin = 0;
   logic        dl_xmt, dl_cmplx, dlfb, ffb;
   logic [7:0]  paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [19:0] sample_i = 20'hABCDE, sample_q = 20'h12345, fo;
   logic [15:0] tx_pattern, beats[$];
   logic [7:0]  ra[6] = '{ADDR_SWAP, ADDR_ACC, ADDR_OUT, ADDR_SYNC, ADDR_CLK, ADDR_FMT};
   logic [15:0] rv[6] = '{RST_SWAP, RST_ACC, RST_OUT, RST_SYNC, RST_CLK, RST_FMT};
   // bypass with zero delay: host clears the count and the ram enable
   logic [15:0] mv[6] = '{MASK_SWAP, 16'h030F, MASK_OUT, MASK_SYNC, MASK_CLK, MASK_FMT};
   int          bad_count = 0, checks = 0, t;
   chan_link link ();
   chan_cfg_device i_chan_cfg_device (.pclk, .presetn, .link, .sample_i, .sample_q,
      .sample_valid, .cic_bypass, .partial_in(pin), .partial_valid(pv), .tx_pattern,
      .pwr_meter_test(pmt), .dl_wr_addr(), .dl_rd_addr(), .dl_xmt, .dl_cmplx,
      .delay_line_forward_bcast(dlfb), .filter_forward_bcast(ffb), .fir_data_valid(fdv),
      .acc_delay(), .partial_sum_zero_delay(), .acc_ram_en(), .filt_out(fo),
      .filt_out_valid(), .filt_cmplx(), .filt_tx_en_i(), .filt_tx_en_q(),
      .fir_resync(rsy), .fir_clk_gate_en());
   chan_cfg_host i_chan_cfg_host (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
      .pwdata, .prdata, .pready, .pslverr, .link);
   chan_link_checker i_chan_link_checker (.pclk, .presetn, .req(link.req), .ack(link.ack),
      .rdata(link.rdata), .fmt_valid(link.fmt_valid), .fmt_first(link.fmt_first));
   initial forever #10 pclk = ~pclk;
   always @(posedge pclk)
      if (link.fmt_valid === 1'b1) beats.push_back(link.fmt_data);
   task automatic check(input string n, input logic [31:0] s, e);
      checks++;
      if (s !== e)
      begin
         bad_count++;
         $display("MISMATCH %s exp %h seen %h", n, e, s);
      end
   endtask
   task automatic final_report();
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // one idle cycle before each setup keeps psel from being driven twice per step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic dev(input logic w, input logic [7:0] a, input logic [15:0] d);
      apb(1, APB_CMD, {23'h0, w, a});
      apb(1, APB_WDATA, {16'h0, d});
      apb(1, APB_GO, 32'h0);
      do
         apb(0, APB_STATUS, 32'h0);
      while (rd[0] !== 1'b0);
   endtask
   task automatic pulse();
      @(posedge pclk);
      sample_valid <= 1;
      @(posedge pclk);
      sample_valid <= 0;
   endtask
   initial
   begin
      repeat (8) @(posedge pclk);
      presetn <= 1;
      foreach (ra[i])
      begin
         dev(0, ra[i], 0);
         check("reset", rd[31:16], rv[i]);
         dev(1, ra[i], 16'hFFFF);
         dev(0, ra[i], 0);
         check("field", rd[31:16], mv[i]);
      end
      check("map", {pmt, dl_xmt, dl_cmplx, ffb, dlfb}, 5'h1F);
      dev(1, ADDR_CKSUM, 16'hFFFF);
      dev(0, ADDR_CKSUM, 0);
      check("cksum", rd[31:16], 16'h0);
      dev(0, 8'h30, 0);
      check("unmapped", rd[31:16], 16'h0);
      apb(0, 8'h40, 0);
      check("pslverr", er, 1'b1);
      presetn <= 0;
      @(posedge pclk);
      presetn <= 1;
      dev(1, ADDR_FMT, 16'h4000);
      @(posedge pclk);
      check("pattern", tx_pattern, PAT_CONST_VAL);
      dev(1, ADDR_FMT, 16'h0911);
      pulse();
      repeat (2) @(posedge pclk);
      check("dvalid", fdv, 1'b1);
      repeat (8) @(posedge pclk);
      check("beats", beats.size(), 4);
      check("i", {beats[0], beats[1]}, 32'hA000B000);
      check("q", {beats[2], beats[3]}, 32'h10002000);
      beats.delete();
      // this sample falls in the other channels' slots and must be dropped
      pulse();
      repeat (10) @(posedge pclk);
      check("tdm", beats.size(), 0);
      dev(1, ADDR_FMT, 16'h0311);
      dev(1, ADDR_SWAP, 16'h1000);
      cic_bypass <= 1;
      pulse();
      @(posedge pclk);
      check("trim", fdv, 1'b1);
      repeat (10) @(posedge pclk);
      check("pwrdn", beats.size(), 0);
      dev(1, ADDR_SYNC, 16'h0003);
      dev(1, ADDR_CLK, 16'h0400);
      while (rsy !== 1'b1) @(posedge pclk);
      t = 0;
      do
      begin
         @(posedge pclk);
         t++;
      end
      while (rsy !== 1'b1);
      check("resync", t, 4);
      dev(1, ADDR_ACC, 16'h0020);
      dev(1, ADDR_OUT, 16'h0041);
      pin <= 24'h000100;
      @(posedge pclk);
      pv <= 1;
      repeat (2) @(posedge pclk);
      pv <= 0;
      @(posedge pclk);
      check("acc", fo, 20'h00040);
      final_report();
   end
   initial
   begin
      repeat (5000) @(posedge pclk);
      bad_count++;
      final_report();
   end
endmodule
`default_nettype wire
